//--- design/ptc_pkg.sv
package ptc_pkg;

  // Counter and register geometry.
  localparam int unsigned PTC_CNT_W   = 10;
  localparam int unsigned PTC_ADDR_W  = 8;
  localparam int unsigned PTC_DATA_W  = 32;
  localparam int unsigned PTC_CTRL_W  = 9;
  localparam int unsigned PTC_SYNC_N  = 2;

  // Register byte offsets on the APB word grid.
  localparam logic [PTC_ADDR_W-1:0] PTC_OFS_CTRL  = 8'h00;
  localparam logic [PTC_ADDR_W-1:0] PTC_OFS_CMPA  = 8'h04;
  localparam logic [PTC_ADDR_W-1:0] PTC_OFS_CMPP  = 8'h08;
  localparam logic [PTC_ADDR_W-1:0] PTC_OFS_COUNT = 8'h0c;

  // Reset values and the counter step.
  localparam logic [PTC_CNT_W-1:0]  PTC_CNT_RST  = 10'h000;
  localparam logic [PTC_CNT_W-1:0]  PTC_CNT_STEP = 10'h001;
  localparam logic [PTC_DATA_W-1:0] PTC_RD_ZERO  = 32'h0000_0000;

  // Index of each pin in the synchroniser bank.
  localparam int unsigned PTC_PIN_TP  = 0;
  localparam int unsigned PTC_PIN_TCK = 1;

  // Operating modes carried by the two mode select bits.
  typedef enum logic [1:0] {
    PTC_MODE_CMP = 2'b00,
    PTC_MODE_CAP = 2'b01,
    PTC_MODE_SP  = 2'b10,
    PTC_MODE_TC  = 2'b11
  } ptc_mode_t;

  // Capture edge choices carried by the pin function bits.
  typedef enum logic [1:0] {
    PTC_EDGE_RISE = 2'b00,
    PTC_EDGE_FALL = 2'b01,
    PTC_EDGE_BOTH = 2'b10,
    PTC_EDGE_NONE = 2'b11
  } ptc_edge_t;

  // Control register layout, bit 0 is run_bit.
  typedef struct packed {
    logic counter_clear_select;   // Bit 8.
    logic capture_source_select;  // Bit 7.
    logic output_polarity;        // Bit 6.
    logic output_level_control;   // Bit 5.
    logic pin_func_hi;            // Bit 4.
    logic pin_func_lo;            // Bit 3.
    logic mode_sel_hi;            // Bit 2.
    logic mode_sel_lo;            // Bit 1.
    logic run_bit;                // Bit 0.
  } ptc_ctrl_t;

  localparam ptc_ctrl_t PTC_CTRL_RST = 9'h000;

  // Edge information of one synchronised pin.
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ptc_pin_t;

endpackage

//--- design/ptc_pin_edge.sv
`timescale 1ns/100ps

// Two-stage synchroniser for one pin plus an edge detector behind it.
module ptc_pin_edge (
  input  wire logic         sys_clk,  // System clock.
  input  wire logic         rst_b,    // Asynchronous reset, active low.
  input  wire logic         clk_en,   // Freezes all state while low.
  input  wire logic         pin,      // Raw pin level, asynchronous.
  output ptc_pkg::ptc_pin_t edge_o    // Synchronised level and edges.
);

  logic [ptc_pkg::PTC_SYNC_N-1:0] sync;
  logic                           last;

  // Only the second stage feeds the detector; the first is left alone.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync <= '0;
      last <= 1'b0;
    end else if (clk_en) begin
      sync <= {sync[0], pin};
      last <= sync[ptc_pkg::PTC_SYNC_N-1];
    end
  end

  // Edges are one-cycle pulses against the previous synchronised level.
  assign edge_o.level = sync[ptc_pkg::PTC_SYNC_N-1];
  assign edge_o.rise  = sync[ptc_pkg::PTC_SYNC_N-1] & ~last;
  assign edge_o.fall  = ~sync[ptc_pkg::PTC_SYNC_N-1] & last;

endmodule

//--- design/ptc_pulse_capture.sv
`timescale 1ns/100ps

module ptc_pulse_capture (
  input  wire logic                            sys_clk,               // 200 MHz clock.
  input  wire logic                            rst_b,                 // Async reset, low.
  input  wire logic                            clk_en,                // Freezes state when low.
  input  wire logic                            psel,                  // APB select.
  input  wire logic                            penable,               // APB enable.
  input  wire logic                            pwrite,                // APB direction.
  input  wire logic [ptc_pkg::PTC_ADDR_W-1:0]  paddr,                 // APB byte address.
  input  wire logic [ptc_pkg::PTC_DATA_W-1:0]  pwdata,                // APB write data.
  output logic      [ptc_pkg::PTC_DATA_W-1:0]  prdata,                // APB read data.
  output logic                                 pready,                // APB ready.
  output logic                                 pslverr,               // APB error.
  input  wire logic                            timer_clock_pin,       // Clock pin input.
  input  wire logic                            timer_output_pin_in,   // Output pin, read back.
  output logic                                 timer_output_pin_out,  // Output pin drive.
  output logic                                 timer_output_pin_oe_b, // Low while driving.
  output logic                                 timer_irq              // Interrupt request.
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  ptc_pkg::ptc_ctrl_t                ctrl;
  logic [ptc_pkg::PTC_CNT_W-1:0]     compare_a_value;
  logic [ptc_pkg::PTC_CNT_W-1:0]     period_compare_value;
  logic [ptc_pkg::PTC_CNT_W-1:0]     count;
  logic                              run_q;

  ptc_pkg::ptc_ctrl_t                next_ctrl;
  logic [ptc_pkg::PTC_CNT_W-1:0]     next_compare_a_value;
  logic [ptc_pkg::PTC_CNT_W-1:0]     next_count;
  logic                              next_irq;
  logic                              next_pin_out;
  logic                              next_pin_oe_b;
  logic [ptc_pkg::PTC_DATA_W-1:0]    next_prdata;

  ptc_pkg::ptc_pin_t                 pin_edge [2];
  logic [1:0]                        raw_pins;

  //////////////////////////////////////////////////////////////////////////////
  // Address decoding.

  // Word hit test; shared by the write strobes and the read mux.
  function automatic logic reg_hit(
    input logic [ptc_pkg::PTC_ADDR_W-1:0] addr,
    input logic [ptc_pkg::PTC_ADDR_W-1:0] ofs
  );
    reg_hit = (addr == ofs);
  endfunction

  wire hit_ctrl  = reg_hit(paddr, ptc_pkg::PTC_OFS_CTRL);
  wire hit_cmpa  = reg_hit(paddr, ptc_pkg::PTC_OFS_CMPA);
  wire hit_cmpp  = reg_hit(paddr, ptc_pkg::PTC_OFS_CMPP);
  wire hit_count = reg_hit(paddr, ptc_pkg::PTC_OFS_COUNT);
  wire hit_any   = hit_ctrl | hit_cmpa | hit_cmpp | hit_count;

  // The slave answers with no wait state unless the clock enable is low,
  // which stretches the access so that no write is lost while frozen.
  wire apb_setup  = psel & ~penable & clk_en;
  wire apb_access = psel & penable & clk_en;
  wire apb_write  = apb_access & pwrite & hit_any;

  wire wr_ctrl = apb_write & hit_ctrl;
  wire wr_cmpa = apb_write & hit_cmpa;
  wire wr_cmpp = apb_write & hit_cmpp;

  assign pready  = clk_en;
  assign pslverr = psel & penable & ~hit_any;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  assign raw_pins[ptc_pkg::PTC_PIN_TP]  = timer_output_pin_in;
  assign raw_pins[ptc_pkg::PTC_PIN_TCK] = timer_clock_pin;

  // The output pin is sampled back even while this block drives it.
  for (genvar gi = 0; gi < 2; gi++) begin : g_pin
    ptc_pin_edge u_edge (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .clk_en  (clk_en),
      .pin     (raw_pins[gi]),
      .edge_o  (pin_edge[gi])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode and counter decoding.

  wire ptc_pkg::ptc_mode_t mode = ptc_pkg::ptc_mode_t'({ctrl.mode_sel_hi, ctrl.mode_sel_lo});
  wire ptc_pkg::ptc_edge_t edge_sel = ptc_pkg::ptc_edge_t'({ctrl.pin_func_hi, ctrl.pin_func_lo});

  wire sp_mode  = (mode == ptc_pkg::PTC_MODE_SP);
  wire cap_mode = (mode == ptc_pkg::PTC_MODE_CAP);
  wire our_mode = sp_mode | cap_mode;

  // A run bit rising edge is seen in the first cycle the register holds the new bit; counting starts one cycle later.
  wire run_rise = ctrl.run_bit & ~run_q;
  wire counting = ctrl.run_bit & run_q & our_mode;

  wire [ptc_pkg::PTC_CNT_W-1:0] count_inc = count + ptc_pkg::PTC_CNT_STEP;

  // A zero period never equals an incremented value below the wrap, so the
  // ten-bit counter passes all 1024 states and clears as it wraps.
  wire period_match = cap_mode & counting
                    & (count_inc == period_compare_value);

  // Single pulse compares only against compare A; the period register and
  // the counter clear select take no part here.
  wire match_a = sp_mode & counting & (count == compare_a_value);

  // The clock pin rising edge is taken as its active edge.
  wire tck_trigger = sp_mode & pin_edge[ptc_pkg::PTC_PIN_TCK].rise;

  //////////////////////////////////////////////////////////////////////////////
  // Capture edge selection.

  // Source select 0 takes the output pin, 1 the clock pin.
  wire ptc_pkg::ptc_pin_t cap_src = ctrl.capture_source_select
                                  ? pin_edge[ptc_pkg::PTC_PIN_TCK]
                                  : pin_edge[ptc_pkg::PTC_PIN_TP];

  logic cap_edge;

  // Pin function 11 suppresses captures without stopping the counter.
  always_comb begin
    unique case (edge_sel)
      ptc_pkg::PTC_EDGE_RISE: cap_edge = cap_src.rise;
      ptc_pkg::PTC_EDGE_FALL: cap_edge = cap_src.fall;
      ptc_pkg::PTC_EDGE_BOTH: cap_edge = cap_src.rise | cap_src.fall;
      ptc_pkg::PTC_EDGE_NONE: cap_edge = 1'b0;
    endcase
  end

  // Captures work whether or not the counter is running.
  wire cap_hit = cap_mode & cap_edge;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Software write wins over the hardware clear, which wins over the pin
  // set; the clear and the set together would otherwise hide the edge.
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = ptc_pkg::ptc_ctrl_t'(pwdata[ptc_pkg::PTC_CTRL_W-1:0]);
    end else if (match_a) begin
      next_ctrl.run_bit = 1'b0;
    end else if (tck_trigger) begin
      next_ctrl.run_bit = 1'b1;
    end
  end

  // A capture in the same cycle as a software write keeps the captured
  // value, since losing a hardware event is worse than losing a write.
  always_comb begin
    next_compare_a_value = compare_a_value;
    if (cap_hit) begin
      next_compare_a_value = count;
    end else if (wr_cmpa) begin
      next_compare_a_value = pwdata[ptc_pkg::PTC_CNT_W-1:0];
    end
  end

  // Counter zeroes on the run rising edge, runs while the run bit stays
  // high and holds its value once the run bit has fallen.
  always_comb begin
    next_count = count;
    if (our_mode && run_rise) begin
      next_count = ptc_pkg::PTC_CNT_RST;
    end else if (period_match) begin
      next_count = ptc_pkg::PTC_CNT_RST;
    end else if (counting) begin
      next_count = count_inc;
    end
  end

  // One interrupt pulse per cycle with a match or capture event; a period match and a capture together give one.
  assign next_irq = match_a | period_match | cap_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Output pin.

  // The pulse follows the run bit, so any clear of it ends the pulse. In
  // capture mode the pin is released and the level bits have no effect.
  wire pulse_active = sp_mode & ctrl.run_bit;
  wire pulse_level  = ctrl.output_level_control
                    ? pulse_active
                    : ~pulse_active;

  assign next_pin_out  = sp_mode & (pulse_level ^ ctrl.output_polarity);
  assign next_pin_oe_b = ~sp_mode;

  //////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Read data is loaded during the setup phase so it is a flip-flop output
  // by the access phase; the counter value is one cycle old as a result.
  always_comb begin
    next_prdata = prdata;
    if (apb_setup) begin
      next_prdata = ptc_pkg::PTC_RD_ZERO;
      if (hit_ctrl) begin
        next_prdata = ptc_pkg::PTC_DATA_W'(ctrl);
      end else if (hit_cmpa) begin
        next_prdata = ptc_pkg::PTC_DATA_W'(compare_a_value);
      end else if (hit_cmpp) begin
        next_prdata = ptc_pkg::PTC_DATA_W'(period_compare_value);
      end else if (hit_count) begin
        next_prdata = ptc_pkg::PTC_DATA_W'(count);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Control, compare values and counter.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl                 <= ptc_pkg::PTC_CTRL_RST;
      compare_a_value      <= ptc_pkg::PTC_CNT_RST;
      period_compare_value <= ptc_pkg::PTC_CNT_RST;
      count                <= ptc_pkg::PTC_CNT_RST;
      run_q                <= 1'b0;
    end else if (clk_en) begin
      ctrl            <= next_ctrl;
      compare_a_value <= next_compare_a_value;
      count           <= next_count;
      run_q           <= ctrl.run_bit;
      if (wr_cmpp) begin
        period_compare_value <= pwdata[ptc_pkg::PTC_CNT_W-1:0];
      end
    end
  end

  // Outputs towards pins, interrupt and bus.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_output_pin_out  <= 1'b0;
      timer_output_pin_oe_b <= 1'b1;
      timer_irq             <= 1'b0;
      prdata                <= ptc_pkg::PTC_RD_ZERO;
    end else if (clk_en) begin
      timer_output_pin_out  <= next_pin_out;
      timer_output_pin_oe_b <= next_pin_oe_b;
      timer_irq             <= next_irq;
      prdata                <= next_prdata;
    end
  end

endmodule

//--- dv/ptc_pin_env.sv
`timescale 1ns/100ps

// Stands in for the outside world at the two timer pins.
module ptc_pin_env (
  input  wire logic tck_lvl,  // Level the source puts on the clock pin.
  input  wire logic tp_lvl,   // Level an outside driver puts on the output pin.
  input  wire logic pin_out,  // Block drive of the output pin.
  input  wire logic oe_b,     // Low while the block drives the pin.
  output logic      tck,      // Clock pin wire.
  output logic      tp        // Output pin wire as every party sees it.
);
  // The block's own drive wins the shared wire, so its own transitions reach
  // the capture readback just as an outside edge would.
  assign tp  = (oe_b === 1'b0) ? pin_out : tp_lvl;
  assign tck = tck_lvl;
endmodule

//--- dv/ptc_pulse_capture_monitor.sv
`timescale 1ns/100ps

// Port-level checks of the bus answer, the interrupt and the output pin.
module ptc_pulse_capture_monitor (
  input wire logic        sys_clk,   // Clock.
  input wire logic        rst_b,     // Reset, active low.
  input wire logic        clk_en,    // Clock enable.
  input wire logic        psel,      // APB select.
  input wire logic        penable,   // APB enable.
  input wire logic [7:0]  paddr,     // APB address.
  input wire logic [31:0] prdata,    // APB read data.
  input wire logic        pready,    // APB ready.
  input wire logic        pslverr,   // APB error.
  input wire logic        timer_output_pin_out,   // Pin drive.
  input wire logic        timer_output_pin_oe_b,  // Pin enable, low drives.
  input wire logic        timer_irq  // Interrupt.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the four mapped words; any other address must be refused.
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c};
  wire acc    = psel && penable;

  // The pulse ends one cycle after the match interrupt, two after the match, because the pin follows run.
  sequence match_end_s;
    timer_irq && !timer_output_pin_oe_b;
  endsequence
  sequence pin_moves_s;
    ##1 $changed(timer_output_pin_out);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  ready_follow_a: assert property (pready == clk_en)
    else $error("pready differs from clk_en");
  map_ok_a: assert property (acc && mapped |-> !pslverr)
    else $error("error on a mapped address");
  unmap_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  err_phase_a: assert property (pslverr |-> acc)
    else $error("error outside an access phase");
  irq_pulse_a: assert property (timer_irq |=> !timer_irq)
    else $error("interrupt longer than one cycle");
  out_idle_a: assert property (timer_output_pin_oe_b |-> !timer_output_pin_out)
    else $error("pin driven level while released");
  pulse_end_a: assert property (match_end_s |-> pin_moves_s)
    else $error("pulse did not end after match");
  rst_out_a: assert property ($rose(rst_b) |-> timer_output_pin_oe_b && !timer_irq)
    else $error("pins wrong after reset");
endmodule

bind ptc_pulse_capture ptc_pulse_capture_monitor ptc_pulse_capture_monitor_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_output_pin_out(timer_output_pin_out),
  .timer_output_pin_oe_b(timer_output_pin_oe_b), .timer_irq(timer_irq));

//--- dv/periodic_tm_pulse_capture_test.sv
`timescale 1ns/100ps

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module periodic_tm_pulse_capture_test;
  logic        sys_clk, rst_b, clk_en, psel, penable, pwrite, tck_lvl, tp_lvl, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, rd2;
  logic [31:0] prdata;
  logic        pready, pslverr, pin_out, oe_b, irq, tck, tp;
  int          num_errors = 0, cmp_count = 0, irq_cnt = 0, n0, w;

  ptc_pulse_capture ptc_pulse_capture_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_clock_pin(tck),
    .timer_output_pin_in(tp), .timer_output_pin_out(pin_out),
    .timer_output_pin_oe_b(oe_b), .timer_irq(irq));
  ptc_pin_env ptc_pin_env_i (.tck_lvl(tck_lvl), .tp_lvl(tp_lvl), .pin_out(pin_out),
    .oe_b(oe_b), .tck(tck), .tp(tp));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a running tally of interrupt pulses.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Raise and drop one pin long enough for the synchroniser to see both edges.
  task automatic pin_pulse(input logic on_tck);
    @(posedge sys_clk);
    if (on_tck) tck_lvl <= 1'b1; else tp_lvl <= 1'b1;
    cyc(6);
    if (on_tck) tck_lvl <= 1'b0; else tp_lvl <= 1'b0;
    cyc(6);
  endtask

  // One single pulse of width CMPA+2, fired by software or by the clock pin.
  task automatic sp_run(input logic olc, input logic pol, input logic by_pin);
    logic [31:0] base;
    logic        act;
    base = 32'h11c | {25'h0, pol, olc, 5'h0};
    act = olc ^ pol;
    wr(8'h00, base);
    cyc(4);
    n0 = irq_cnt;
    w = 0;
    // The clock pin stays high through the whole window, so the pulse is
    // counted while it stands; its later fall leaves the run bit alone.
    if (by_pin) begin
      @(posedge sys_clk);
      tck_lvl <= 1'b1;
    end else begin
      wr(8'h00, base | 32'h1);
    end
    repeat (40) begin
      @(posedge sys_clk);
      if (oe_b === 1'b0 && pin_out === act) w++;
    end
    tck_lvl <= 1'b0;
    `CHK(w, 7)
    `CHK(irq_cnt - n0, 1)
    chk_rd(8'h00, base);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, tck_lvl, tp_lvl, rst_b} = 6'h00;
    {paddr, pwdata} = 40'h0;
    clk_en = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a += 4) chk_rd(a[7:0], 32'h0);
    `CHK(oe_b, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(last_err, 1'b1)
    // Single pulse: period register set small to show it has no effect.
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h3);
    for (int k = 0; k < 4; k++) sp_run(k[0], k[1], k > 1);
    // Capture: every edge code on both sources; the other pin must stay unheard.
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h163 | {24'h0, k[2], 2'h0, k[1:0], 3'h0});
      cyc(5);
      n0 = irq_cnt;
      pin_pulse(!k[2]);
      pin_pulse(k[2]);
      `CHK(irq_cnt - n0, (k[1:0] == 3) ? 0 : (k[1:0] == 2) ? 2 : 1)
      apb(1'b0, 8'h04, 32'h0);
      `CHK(rd !== 32'h0, k[1:0] != 3)
    end
    apb(1'b0, 8'h0c, 32'h0);
    rd2 = rd;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd !== rd2, 1'b1)
    // A low clock enable freezes the counter, so the frozen gap adds no counts.
    rd2 = rd;
    clk_en <= 1'b0;
    cyc(20);
    clk_en <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd - rd2, 32'h3)
    wr(8'h00, 32'h1a);
    apb(1'b0, 8'h0c, 32'h0);
    rd2 = rd;
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, rd2)
    // Period match every four counts, then the full ten-bit range.
    wr(8'h08, 32'h4);
    wr(8'h00, 32'h1b);
    cyc(5);
    n0 = irq_cnt;
    cyc(40);
    `CHK(irq_cnt - n0, 10)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(rd < 32'h4, 1'b1)
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1a);
    wr(8'h00, 32'h1b);
    cyc(100);
    n0 = irq_cnt;
    cyc(2048);
    `CHK(irq_cnt - n0, 2)
    wrap_up;
  end

  // Tests need about 2900 cycles; the limit allows over four times that.
  initial begin
    #60000;
    num_errors++;
    wrap_up;
  end

  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
endmodule
